// file: rtl/qrt_pkg.sv
// Constants and carrier types for the quick RAM test engine
package qrt_pkg;
	// Command address prefixes
	localparam logic [3:0]  CMD_PREFIX    = 4'h2;
	localparam logic [15:0] RES_PREFIX    = 16'hF000;
	localparam logic [7:0]  RES_PAGE      = 8'h20;
	// Result location offsets inside the result page
	localparam logic [7:0]  OFS_START_LO  = 8'h00;
	localparam logic [7:0]  OFS_START_HI  = 8'h02;
	localparam logic [7:0]  OFS_END_LO    = 8'h04;
	localparam logic [7:0]  OFS_END_HI    = 8'h06;
	localparam logic [7:0]  OFS_ERR_LO    = 8'h08;
	localparam logic [7:0]  OFS_ERR_HI    = 8'h0A;
	localparam logic [7:0]  OFS_EXPECT    = 8'h0C;
	localparam logic [7:0]  OFS_ACTUAL    = 8'h0E;
	localparam logic [7:0]  OFS_MASK      = 8'h12;
	localparam logic [3:0]  OFS_CODE_HI   = 4'hF;
	// Command field positions
	localparam int          FC_LSB        = 24;
	localparam int          BYTE_BIT      = 27;
	localparam logic [3:0]  END_TAG       = 4'h1;
	// Status codes
	localparam logic [7:0]  ST_NONE       = 8'h00;
	localparam logic [7:0]  ST_ABORT_CMD  = 8'hA0;
	localparam logic [7:0]  ST_ABORT_DATA = 8'hA1;
	localparam logic [7:0]  ST_ABORT_ADDR = 8'hA2;
	localparam logic [7:0]  ST_ABORT_INC  = 8'hA3;
	localparam logic [7:0]  ST_BUSY_RW    = 8'hB0;
	localparam logic [7:0]  ST_BUSY_DEC   = 8'hB1;
	localparam logic [7:0]  ST_DONE       = 8'hC0;
	localparam logic [7:0]  ST_FAIL_RW    = 8'hF0;
	localparam logic [7:0]  ST_FAIL_DEC   = 8'hF1;
	// Default increments in bytes
	localparam logic [3:0]  INC_WORD      = 4'h2;
	localparam logic [3:0]  INC_BYTE      = 4'h1;
	// Reset values
	localparam logic [23:0] ADDR_RST      = 24'h000000;
	localparam logic [15:0] WORD_RST      = 16'h0000;

	// Host command into the pod
	typedef struct packed {
		logic        write;
		logic [31:0] addr;
		logic [15:0] data;
	} qrt_cmd_t;

	// Access on the target processor bus
	typedef struct packed {
		logic        req;
		logic        we;
		logic        byte_mode;
		logic [2:0]  fc;
		logic [23:0] addr;
		logic [15:0] wdata;
	} qrt_bus_t;

	// Engine states
	typedef enum logic [2:0] {
		S_IDLE, S_W1, S_R1, S_W0, S_R0, S_WP, S_DR
	} qrt_state_t;
endpackage : qrt_pkg

// file: rtl/qrt_engine.sv
// Quick RAM test engine: two-phase memory test over the target bus
// Function
// - Read/write phase, then address-decoding phase.
// - Write and read ones and zeros per address.
// - Leave unique pattern at every address.
// - Decode phase reads, compares, flags mismatch.
// - Zero increment means two word, one byte.
// - End above start; word addresses even.
// - Odd increment in word mode is illegal.
// - End command function code used throughout.
// - Test starts right after end command.
// - Results only given when host reads.
// - Any other operation aborts running test.
// - Status read low byte is status code.
// - Status high byte is address bits 19:12 while busy, 00 when idle.
// - Early result read aborts, returns old values.
// - Byte mode increment two tests odd bytes.
// - Status codes 00, A0-A3, B0/B1, C0, F0/F1.
// - Result page gives addresses, expected, actual.
// - Read/write fail mask marks bad bits.
`timescale 1ns/10ps
module qrt_engine
	import qrt_pkg::*;
(
	input  wire logic     mclk,
	input  wire logic     reset,
	input  wire logic     ce,
	input  wire logic     cmd_valid,
	input  wire qrt_cmd_t cmd,
	output qrt_bus_t      bus_q,
	input  wire logic     bus_ack,
	input  wire logic [15:0] bus_rdata,
	output logic          rsp_valid_q,
	output logic [15:0]   rsp_data_q
);
	qrt_state_t  state_q,  state_d;
	qrt_bus_t    bus_d;
	logic        rsp_valid_d;
	logic [15:0] rsp_data_d;
	logic [7:0]  code_q,   code_d;
	logic [23:0] start_q,  start_d;
	logic [23:0] end_q,    end_d;
	logic [23:0] cur_q,    cur_d;
	logic [3:0]  inc_q,    inc_d;
	logic [2:0]  fc_q,     fc_d;
	logic        bmode_q,  bmode_d;
	// Published results of the last finished test
	logic [23:0] r_start_q, r_start_d;
	logic [23:0] r_end_q,   r_end_d;
	logic [23:0] r_err_q,   r_err_d;
	logic [15:0] r_exp_q,   r_exp_d;
	logic [15:0] r_act_q,   r_act_d;
	logic [15:0] r_mask_q,  r_mask_d;

	// Pattern unique to an address within the data width
	function automatic logic [15:0] pat(input logic [23:0] a,
		input logic bm);
		logic [15:0] p;
		p = a[15:0] ^ {a[23:16], 8'h00};
		if (bm)
			p = {8'h00, a[7:0]};
		return p;
	endfunction : pat

	logic        busy;
	logic [15:0] dmask;
	logic [24:0] nxt;
	logic        last;
	logic [15:0] bad;
	logic [3:0]  z;
	logic [3:0]  inc_new;
	logic        bm_new;
	logic [23:0] a_new;

	// Next-state logic: bus engine first, host command overrides
	always_comb begin
		state_d     = state_q;
		bus_d       = bus_q;
		rsp_valid_d = 1'b0;
		rsp_data_d  = rsp_data_q;
		code_d      = code_q;
		start_d     = start_q;
		end_d       = end_q;
		cur_d       = cur_q;
		inc_d       = inc_q;
		fc_d        = fc_q;
		bmode_d     = bmode_q;
		r_start_d   = r_start_q;
		r_end_d     = r_end_q;
		r_err_d     = r_err_q;
		r_exp_d     = r_exp_q;
		r_act_d     = r_act_q;
		r_mask_d    = r_mask_q;
		busy    = (state_q != S_IDLE);
		dmask   = bmode_q ? 16'h00FF : 16'hFFFF;
		nxt     = {1'b0, cur_q} + {21'h000000, inc_q};
		last    = (nxt > {1'b0, end_q});
		bad     = 16'h0000;
		z       = cmd.data[7:4];
		bm_new  = cmd.addr[BYTE_BIT];
		a_new   = cmd.addr[23:0];
		inc_new = (z != 4'h0) ? z : (bm_new ? INC_BYTE : INC_WORD);

		// Bus engine: one access completes per acknowledged cycle
		if (busy && bus_q.req && bus_ack) begin
			case (state_q)
				S_W1: begin
					state_d     = S_R1;
					bus_d.we    = 1'b0;
				end
				S_R1: begin
					bad = ~bus_rdata & dmask;
					if (bad != 16'h0000) begin
						state_d   = S_IDLE;
						bus_d.req = 1'b0;
						code_d    = ST_FAIL_RW;
						r_exp_d   = dmask;
						r_act_d   = bus_rdata & dmask;
						r_mask_d  = bad;
					end else begin
						state_d     = S_W0;
						bus_d.we    = 1'b1;
						bus_d.wdata = WORD_RST;
					end
				end
				S_W0: begin
					state_d  = S_R0;
					bus_d.we = 1'b0;
				end
				S_R0: begin
					bad = bus_rdata & dmask;
					if (bad != 16'h0000) begin
						state_d   = S_IDLE;
						bus_d.req = 1'b0;
						code_d    = ST_FAIL_RW;
						r_exp_d   = WORD_RST;
						r_act_d   = bus_rdata & dmask;
						r_mask_d  = bad;
					end else begin
						state_d     = S_WP;
						bus_d.we    = 1'b1;
						bus_d.wdata = pat(cur_q, bmode_q);
					end
				end
				S_WP: begin
					if (last) begin
						state_d     = S_DR;
						code_d      = ST_BUSY_DEC;
						cur_d       = start_q;
						bus_d.addr  = start_q;
						bus_d.we    = 1'b0;
					end else begin
						state_d     = S_W1;
						cur_d       = nxt[23:0];
						bus_d.addr  = nxt[23:0];
						bus_d.wdata = dmask;
					end
				end
				S_DR: begin
					bad = (bus_rdata ^ pat(cur_q, bmode_q)) & dmask;
					if (bad != 16'h0000) begin
						state_d   = S_IDLE;
						bus_d.req = 1'b0;
						code_d    = ST_FAIL_DEC;
						r_exp_d   = pat(cur_q, bmode_q);
						r_act_d   = bus_rdata & dmask;
						r_mask_d  = bad;
					end else if (last) begin
						state_d   = S_IDLE;
						bus_d.req = 1'b0;
						code_d    = ST_DONE;
						r_exp_d   = WORD_RST;
						r_act_d   = WORD_RST;
						r_mask_d  = WORD_RST;
					end else begin
						cur_d      = nxt[23:0];
						bus_d.addr = nxt[23:0];
					end
				end
				default: begin
					state_d   = S_IDLE;
					bus_d.req = 1'b0;
				end
			endcase
			// Publish results once the test has ended
			if (state_d == S_IDLE) begin
				r_start_d = start_q;
				r_end_d   = end_q;
				r_err_d   = (code_d == ST_DONE) ? ADDR_RST : cur_q;
			end
		end

		// Host command handling
		if (cmd_valid) begin
			if (cmd.addr[31:28] == CMD_PREFIX) begin
				if (!cmd.write) begin
					rsp_valid_d = 1'b1;
					rsp_data_d  = {busy ? cur_q[19:12] : 8'h00,
						code_q};
				end else begin
					state_d   = S_IDLE;
					bus_d.req = 1'b0;
					code_d    = busy ? ST_ABORT_CMD : code_q;
					if (cmd.data == WORD_RST) begin
						start_d = a_new;
					end else if (cmd.data[3:0] != END_TAG ||
						cmd.data[15:8] != 8'h00) begin
						code_d = ST_ABORT_DATA;
					end else if (a_new <= start_q ||
						(!bm_new && (a_new[0] || start_q[0]))) begin
						code_d = ST_ABORT_ADDR;
					end else if (!bm_new && inc_new[0]) begin
						code_d = ST_ABORT_INC;
					end else begin
						// Start at once with the new range
						state_d     = S_W1;
						code_d      = ST_BUSY_RW;
						end_d       = a_new;
						inc_d       = inc_new;
						bmode_d     = bm_new;
						fc_d        = cmd.addr[FC_LSB +: 3];
						cur_d       = start_q;
						bus_d.req   = 1'b1;
						bus_d.we    = 1'b1;
						bus_d.byte_mode = bm_new;
						bus_d.fc    = cmd.addr[FC_LSB +: 3];
						bus_d.addr  = start_q;
						bus_d.wdata = bm_new ? 16'h00FF : 16'hFFFF;
					end
				end
			end else if (cmd.addr[31:16] == RES_PREFIX &&
				cmd.addr[15:8] == RES_PAGE && !cmd.write) begin
				rsp_valid_d = 1'b1;
				case (cmd.addr[7:0])
					OFS_START_LO: rsp_data_d = r_start_q[15:0];
					OFS_START_HI: rsp_data_d = {8'h00, r_start_q[23:16]};
					OFS_END_LO:   rsp_data_d = r_end_q[15:0];
					OFS_END_HI:   rsp_data_d = {8'h00, r_end_q[23:16]};
					OFS_ERR_LO:   rsp_data_d = r_err_q[15:0];
					OFS_ERR_HI:   rsp_data_d = {8'h00, r_err_q[23:16]};
					OFS_EXPECT:   rsp_data_d = r_exp_q;
					OFS_ACTUAL:   rsp_data_d = r_act_q;
					OFS_MASK:     rsp_data_d = r_mask_q;
					default:      rsp_data_d = (cmd.addr[7:4] == OFS_CODE_HI)
						? {8'h00, code_q} : WORD_RST;
				endcase
				if (busy) begin
					state_d   = S_IDLE;
					bus_d.req = 1'b0;
					code_d    = ST_ABORT_CMD;
				end
			end else if (busy) begin
				state_d   = S_IDLE;
				bus_d.req = 1'b0;
				code_d    = ST_ABORT_CMD;
			end
		end
	end

	// State registers, frozen while ce is low
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_q     <= S_IDLE;
			bus_q       <= '0;
			rsp_valid_q <= 1'b0;
			rsp_data_q  <= WORD_RST;
			code_q      <= ST_NONE;
			start_q     <= ADDR_RST;
			end_q       <= ADDR_RST;
			cur_q       <= ADDR_RST;
			inc_q       <= INC_WORD;
			fc_q        <= 3'h0;
			bmode_q     <= 1'b0;
			r_start_q   <= ADDR_RST;
			r_end_q     <= ADDR_RST;
			r_err_q     <= ADDR_RST;
			r_exp_q     <= WORD_RST;
			r_act_q     <= WORD_RST;
			r_mask_q    <= WORD_RST;
		end else if (ce) begin
			state_q     <= state_d;
			bus_q       <= bus_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_data_q  <= rsp_data_d;
			code_q      <= code_d;
			start_q     <= start_d;
			end_q       <= end_d;
			cur_q       <= cur_d;
			inc_q       <= inc_d;
			fc_q        <= fc_d;
			bmode_q     <= bmode_d;
			r_start_q   <= r_start_d;
			r_end_q     <= r_end_d;
			r_err_q     <= r_err_d;
			r_exp_q     <= r_exp_d;
			r_act_q     <= r_act_d;
			r_mask_q    <= r_mask_d;
		end
	end
endmodule : qrt_engine

// file: tb/qrt_monitor.sv
// Port checker for the quick RAM test engine
`timescale 1ns/10ps
module qrt_monitor
	import qrt_pkg::*;
(
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic        ce,
	input wire logic        cmd_valid,
	input wire qrt_cmd_t    cmd,
	input wire qrt_bus_t    bus_q,
	input wire logic        bus_ack,
	input wire logic [15:0] bus_rdata,
	input wire logic        rsp_valid_q,
	input wire logic [15:0] rsp_data_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset || !ce);
	// Host reads that get an answer, and commands that abort a test
	wire st = cmd_valid && !cmd.write && cmd.addr[31:28] == CMD_PREFIX;
	wire rs = cmd_valid && !cmd.write
		&& cmd.addr[31:8] == {RES_PREFIX, RES_PAGE};
	wire ot = cmd_valid && cmd.addr[31:28] != CMD_PREFIX;
	// Ones written and taken, then the same place read back
	sequence ones_wr;
		bus_q.req && bus_q.we && bus_ack && !cmd_valid
			&& bus_q.wdata == 16'hFFFF;
	endsequence
	sequence rd_back;
		bus_q.req && !bus_q.we && $stable(bus_q.addr);
	endsequence
	a_read_answered: assert property ((st || rs) |=> rsp_valid_q)
		else $error("read unanswered");
	a_no_unasked: assert property (rsp_valid_q |-> $past(st || rs))
		else $error("answer unasked");
	a_bus_hold: assert property (bus_q.req && !bus_ack && !cmd_valid
		|=> $stable(bus_q)) else $error("access changed");
	a_abort_drop: assert property (ot && bus_q.req |=> !bus_q.req)
		else $error("abort ignored");
	a_rw_order: assert property (ones_wr |=> rd_back)
		else $error("no read back");
	a_fc_steady: assert property (bus_q.req && $past(bus_q.req)
		&& !$past(cmd_valid) |-> $stable(bus_q.fc)) else $error("fc moved");
	a_busy_track: assert property (rsp_valid_q && $past(st)
		&& rsp_data_q[7:4] == 4'hB
		|-> rsp_data_q[15:8] == $past(bus_q.addr[19:12]))
		else $error("no progress");
	a_byte_lane: assert property (bus_q.req && bus_q.we
		&& bus_q.byte_mode |-> bus_q.wdata[15:8] == 8'h00)
		else $error("byte lane");
endmodule : qrt_monitor
bind qrt_engine qrt_monitor i_mon (.mclk(mclk), .reset(reset), .ce(ce),
	.cmd_valid(cmd_valid), .cmd(cmd), .bus_q(bus_q), .bus_ack(bus_ack),
	.bus_rdata(bus_rdata), .rsp_valid_q(rsp_valid_q),
	.rsp_data_q(rsp_data_q));

// file: tb/qrt_ram_model.sv
// Target RAM with set latency, a stuck bit mask and address aliasing
`timescale 1ns/10ps
module qrt_ram_model
	import qrt_pkg::*;
(
	input wire logic        mclk,
	input wire logic        reset,
	input wire qrt_bus_t    bus,
	input wire logic [1:0]  lag,
	input wire logic [15:0] stuck,
	input wire logic [8:0]  alias_m,
	output logic            ack,
	output logic [15:0]     rdata
);
	logic [15:0] mem [0:511];
	logic [1:0]  cnt;
	wire  [8:0]  a = bus.addr[8:0] & ~alias_m;
	// Answer lag+1 cycles after a request; data toggles while no answer stands
	always_ff @(posedge mclk) begin
		ack <= 1'b0;
		rdata <= ~rdata;
		cnt <= cnt + 2'h1;
		if (reset || !bus.req || ack) begin
			cnt <= 2'h0;
			if (reset) rdata <= 16'h5A5A;
		end else if (cnt == lag) begin
			ack <= 1'b1;
			rdata <= mem[a] | stuck;
			if (bus.we) mem[a] <= bus.wdata;
		end
	end
endmodule : qrt_ram_model

// file: tb/qrt_engine_tb.sv
// Self-checking bench for the quick RAM test engine
`timescale 1ns/10ps
module qrt_engine_tb
	import qrt_pkg::*;
;
	logic        mclk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, ce = 1'b1;
	logic        bus_ack, rsp_valid_q;
	logic [15:0] bus_rdata, rsp_data_q, stuck = 16'h0000;
	logic [8:0]  alias_m = 9'h000;
	logic [1:0]  lag = 2'h0;
	qrt_cmd_t    cmd = '0;
	qrt_bus_t    bus_q;
	int          failures = 0, samples_checked = 0, n_wr = 0, n_base = 0;
	initial forever #25 mclk = ~mclk;
	qrt_engine i_dut (.mclk(mclk), .reset(reset), .ce(ce),
		.cmd_valid(cmd_valid), .cmd(cmd), .bus_q(bus_q),
		.bus_ack(bus_ack), .bus_rdata(bus_rdata),
		.rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q));
	qrt_ram_model i_ram (.mclk(mclk), .reset(reset), .bus(bus_q),
		.lag(lag), .stuck(stuck), .alias_m(alias_m),
		.ack(bus_ack), .rdata(bus_rdata));
	// Count writes taken by the engine; acks while frozen are not taken
	always @(posedge mclk) if (ce && bus_q.req && bus_ack && bus_q.we) n_wr++;
	task automatic chk(string nm, logic [15:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test
	task automatic send(logic w, logic [31:0] a, logic [15:0] d);
		@(negedge mclk);
		cmd_valid = 1'b1;
		cmd = '{w, a, d};
		@(negedge mclk);
		cmd_valid = 1'b0;
		if (!w) chk("rsp", {15'h0, rsp_valid_q}, 16'h0001);
	endtask : send
	task automatic spec(logic [31:0] s, e, logic [15:0] d);
		n_base = n_wr;
		send(1'b1, s, 16'h0000);
		send(1'b1, e, d);
	endtask : spec
	// Poll the status word under a bound
	task automatic status(logic [7:0] c);
		int i;
		i = 0;
		do begin
			send(1'b0, 32'h2000_0000, 16'h0000);
			i++;
		end while (i < 600 && rsp_data_q[7:0] !== c);
		chk("code", {8'h00, rsp_data_q[7:0]}, {8'h00, c});
		if (rsp_data_q[7:0] !== c) end_of_test();
	endtask : status
	task automatic t_word_pass;
		spec(32'h2500_0100, 32'h2500_011E, 16'h0001);
		chk("req", {15'h0, bus_q.req}, 16'h0001);
		chk("ones", bus_q.wdata, 16'hFFFF);
		chk("fc", {13'h0, bus_q.fc}, 16'h0005);
		status(ST_DONE);
		chk("writes", 16'(n_wr - n_base), 16'h0030);
		chk("pattern", i_ram.mem[9'h11E], 16'h011E);
		send(1'b0, 32'hF000_2004, 16'h0000);
		chk("end", rsp_data_q, 16'h011E);
	endtask : t_word_pass
	task automatic t_byte_odd;
		spec(32'h2D00_0101, 32'h2D00_011F, 16'h0021);
		status(ST_DONE);
		chk("writes", 16'(n_wr - n_base), 16'h0030);
		chk("odd", i_ram.mem[9'h11F], 16'h001F);
		spec(32'h2D00_0140, 32'h2D00_0143, 16'h0001);
		status(ST_DONE);
		chk("writes", 16'(n_wr - n_base), 16'h000C);
	endtask : t_byte_odd
	task automatic t_illegal;
		spec(32'h2500_0100, 32'h2500_011E, 16'h0005);
		status(ST_ABORT_DATA);
		spec(32'h2500_0100, 32'h2500_0100, 16'h0001);
		status(ST_ABORT_ADDR);
		spec(32'h2500_0100, 32'h2500_0111, 16'h0001);
		status(ST_ABORT_ADDR);
		spec(32'h2500_0100, 32'h2500_011E, 16'h0031);
		status(ST_ABORT_INC);
		chk("writes", 16'(n_wr - n_base), 16'h0000);
	endtask : t_illegal
	task automatic t_faults;
		stuck = 16'h0008;
		spec(32'h2500_0100, 32'h2500_011E, 16'h0001);
		status(ST_FAIL_RW);
		send(1'b0, 32'hF000_2012, 16'h0000);
		chk("mask", rsp_data_q, 16'h0008);
		send(1'b0, 32'hF000_2008, 16'h0000);
		chk("err", rsp_data_q, 16'h0100);
		stuck = 16'h0000;
		alias_m = 9'h020;
		spec(32'h2500_0100, 32'h2500_013E, 16'h0001);
		status(ST_FAIL_DEC);
		send(1'b0, 32'hF000_200E, 16'h0000);
		chk("actual", rsp_data_q, 16'h0120);
		alias_m = 9'h000;
	endtask : t_faults
	task automatic t_abort;
		lag = 2'h3;
		spec(32'h2500_0100, 32'h2500_013E, 16'h0001);
		send(1'b1, 32'h1000_0000, 16'h1234);
		chk("req", {15'h0, bus_q.req}, 16'h0000);
		status(ST_ABORT_CMD);
		spec(32'h2500_0200, 32'h2500_023E, 16'h0001);
		send(1'b0, 32'hF000_2000, 16'h0000);
		chk("old", rsp_data_q, 16'h0100);
		status(ST_ABORT_CMD);
		lag = 2'h0;
	endtask : t_abort
	// Freeze mid-test, ignore a command while frozen, then reset after the test is done
	task automatic t_freeze;
		spec(32'h2500_0100, 32'h2500_011E, 16'h0001);
		ce = 1'b0;
		repeat (3) @(negedge mclk);
		chk("frz addr", bus_q.addr[15:0], 16'h0100);
		chk("frz data", bus_q.wdata, 16'hFFFF);
		cmd_valid = 1'b1;
		cmd = '{1'b1, 32'h1000_0000, 16'h0000};
		@(negedge mclk);
		cmd_valid = 1'b0;
		ce = 1'b1;
		chk("frz req", {15'h0, bus_q.req}, 16'h0001);
		status(ST_DONE);
		chk("writes", 16'(n_wr - n_base), 16'h0030);
		reset = 1'b1;
		repeat (2) @(negedge mclk);
		reset = 1'b0;
		send(1'b0, 32'h2000_0000, 16'h0000);
		chk("rst code", rsp_data_q, 16'h0000);
		send(1'b0, 32'hF000_2004, 16'h0000);
		chk("rst end", rsp_data_q, 16'h0000);
	endtask : t_freeze
	// Main sequence
	initial begin
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		send(1'b0, 32'h2000_0000, 16'h0000);
		chk("idle", rsp_data_q, 16'h0000);
		t_word_pass();
		t_byte_odd();
		t_illegal();
		t_faults();
		t_abort();
		t_freeze();
		end_of_test();
	end
endmodule : qrt_engine_tb
